//--- include/ppm_defs.svh
// register offsets, field positions and reset values of the port pin mux
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

`define PPM_ADDR_PAGE 8'h80
`define PPM_ADDR_SRC01 8'h81
`define PPM_ADDR_SRC23 8'h82
`define PPM_ADDR_INVDRV 8'h83
`define PPM_ADDR_RUNLVL 8'h84

`define PPM_RST_PAGE 8'h00
`define PPM_RST_SRC01 8'h50
`define PPM_RST_SRC23 8'h12
`define PPM_RST_INVDRV 8'h00
`define PPM_RST_RUNLVL 8'hFF

`define PPM_SEL_HI_MSB 7
`define PPM_SEL_HI_LSB 4
`define PPM_SEL_LO_MSB 3
`define PPM_SEL_LO_LSB 0
`define PPM_INV_LSB 0
`define PPM_DRV_LSB 4
`define PPM_PAGE_BIT 0
`define PPM_RUN_P0A 0
`define PPM_RUN_P0B 1
`define PPM_RUN_P1A 4
`define PPM_RUN_P1B 5

`define PPM_PAGED_LIMIT 8'h80
`define PPM_UNMAPPED_DATA 8'h00

`endif

//--- include/ppm_pkg.sv
// types shared by the port pin mux modules
package ppm_pkg;

  typedef enum logic [3:0] {
    PPM_SRC_CLKOUT = 4'h0,
    PPM_SRC_RUNNING = 4'h1,
    PPM_SRC_IRQ_N = 4'h2,
    PPM_SRC_LOW = 4'h3,
    PPM_SRC_HIGH = 4'h4,
    PPM_SRC_DATA = 4'h5,
    PPM_SRC_MFDATA = 4'h6,
    PPM_SRC_CHIPDATA = 4'h8,
    PPM_SRC_CHIPSTROBE = 4'h9,
    PPM_SRC_RXDATA = 4'hA,
    PPM_SRC_RXSTROBE = 4'hB
  } ppm_src_e;

  typedef logic [3:0] ppm_sel_t;
  typedef logic [7:0] ppm_byte_t;

endpackage : ppm_pkg

//--- verilog/ppm_src_sel.sv
// one pin's source selector, polarity and inversion stage
`timescale 1ns/1ps
module ppm_src_sel #(
  parameter bit CLKOUT_ALLOWED = 1'b1
) (
  input wire ppm_pkg::ppm_sel_t sel,
  input wire logic invert,
  input wire logic runningLevel,
  input wire logic clkOut,
  input wire logic running,
  input wire logic interruptRequestN,
  input wire logic dataOut,
  input wire logic matchedFilterData,
  input wire logic chipData,
  input wire logic chipStrobe,
  input wire logic receivedData,
  input wire logic receivedStrobe,
  output logic pinValue
);
  import ppm_pkg::*;

  logic chosen;

  always_comb begin
    case (sel)
      PPM_SRC_CLKOUT: begin
        chosen = CLKOUT_ALLOWED ? clkOut : 1'b0; // see R02 R03 R04
      end
      // active-low level when the polarity bit is clear
      PPM_SRC_RUNNING: chosen = runningLevel ? running : ~running; // see R07
      PPM_SRC_IRQ_N: chosen = interruptRequestN;
      PPM_SRC_LOW: chosen = 1'b0;
      PPM_SRC_HIGH: chosen = 1'b1;
      PPM_SRC_DATA: chosen = dataOut;
      PPM_SRC_MFDATA: chosen = matchedFilterData;
      PPM_SRC_CHIPDATA: chosen = chipData;
      PPM_SRC_CHIPSTROBE: chosen = chipStrobe;
      PPM_SRC_RXDATA: chosen = receivedData;
      PPM_SRC_RXSTROBE: chosen = receivedStrobe;
      // unused codes park low so the pin never floats to a random source
      default: chosen = 1'b0; // see R13
    endcase
    pinValue = chosen ^ invert; // see R05 R12
  end

endmodule : ppm_src_sel

//--- verilog/ppm_port_pin_mux.sv
// output multiplexer and configuration registers for four port pins
`timescale 1ns/1ps
`include "ppm_defs.svh"

// What this block does
// R01: pin 1 source from bits 7:4 of select register, reset code 5.
// R02: pin 0 source from bits 3:0, same codes, reset to clock out.
// R03: pin 3 source from bits 7:4, no clock out, reset running.
// R04: pin 2 source from bits 3:0, full codes, reset interrupt.
// R05: per-pin invert bits 3..0 for pins 3..0, reset not inverted.
// R06: per-pin strong drive bits 7..4 for pins 3..0, reset normal.
// R07: config B, pin 1 running level follows bit 5, reset high.
// R08: config A, pin 1 running level follows bit 4, reset high.
// R09: config B, pin 0 running level follows bit 1, reset high.
// R10: config A, pin 0 running level follows bit 0; spare bits reset ones.
// R11: page bit picks config set A (000h) or B (100h) for the port.
// R12: inversion applied last, after selection and running polarity.
// R13: software must not program unused selector codes.
module ppm_port_pin_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgWrStrobe,
  input wire logic cfgRdStrobe,
  input wire ppm_pkg::ppm_byte_t cfgAddr,
  input wire ppm_pkg::ppm_byte_t cfgWrData,
  output ppm_pkg::ppm_byte_t cfgRdData,
  output logic cfgRdValid,
  output logic [8:0] pagedAddr,
  output logic configPageSelect,
  input wire logic configBActive,
  input wire logic clkOut,
  input wire logic running,
  input wire logic interruptRequestN,
  input wire logic dataOut,
  input wire logic matchedFilterData,
  input wire logic chipData,
  input wire logic chipStrobe,
  input wire logic receivedData,
  input wire logic receivedStrobe,
  output logic [3:0] portPin,
  output logic [3:0] pinStrongDrive
);
  import ppm_pkg::*;

  ppm_byte_t pageReg, pageNext;
  ppm_byte_t src01Reg, src01Next;
  ppm_byte_t src23Reg, src23Next;
  ppm_byte_t invDrvReg, invDrvNext;
  ppm_byte_t runLvlReg, runLvlNext;
  ppm_byte_t rdDataReg, rdDataNext;
  logic rdValidReg, rdValidNext;
  logic [8:0] pagedReg, pagedNext;
  logic [3:0] pinReg, pinNext;
  logic [3:0] drvReg, drvNext;
  logic [3:0] pinComb;
  logic [3:0] runLevel;
  ppm_sel_t pinSel [4];

  function automatic ppm_byte_t readMux(input ppm_byte_t addr,
      input ppm_byte_t pg, input ppm_byte_t s01, input ppm_byte_t s23,
      input ppm_byte_t idv, input ppm_byte_t rl);
    case (addr)
      `PPM_ADDR_PAGE: readMux = {7'h00, pg[`PPM_PAGE_BIT]};
      `PPM_ADDR_SRC01: readMux = s01;
      `PPM_ADDR_SRC23: readMux = s23;
      `PPM_ADDR_INVDRV: readMux = idv;
      `PPM_ADDR_RUNLVL: readMux = rl;
      default: readMux = `PPM_UNMAPPED_DATA;
    endcase
  endfunction : readMux

  // even pins take the low nibble, odd pins the high one
  function automatic ppm_sel_t selField(input ppm_byte_t cfg, input bit hi);
    if (hi) begin
      selField = cfg[`PPM_SEL_HI_MSB:`PPM_SEL_HI_LSB];
    end else begin
      selField = cfg[`PPM_SEL_LO_MSB:`PPM_SEL_LO_LSB];
    end
  endfunction : selField

  // running polarity of a pin follows the active configuration set
  function automatic logic levelFor(input logic cfgB, input logic lvlB,
      input logic lvlA);
    if (cfgB) begin
      levelFor = lvlB;
    end else begin
      levelFor = lvlA;
    end
  endfunction : levelFor

  // register writes; unmapped addresses are ignored
  always_comb begin
    pageNext = pageReg;
    src01Next = src01Reg;
    src23Next = src23Reg;
    invDrvNext = invDrvReg;
    runLvlNext = runLvlReg;
    if (cfgWrStrobe) begin
      case (cfgAddr)
        // only the page bit is stored; upper bits read zero
        `PPM_ADDR_PAGE: begin
          pageNext = {7'h00, cfgWrData[`PPM_PAGE_BIT]}; // see R11
        end
        `PPM_ADDR_SRC01: src01Next = cfgWrData; // see R01 R02
        `PPM_ADDR_SRC23: src23Next = cfgWrData; // see R03 R04
        `PPM_ADDR_INVDRV: invDrvNext = cfgWrData; // see R05 R06
        `PPM_ADDR_RUNLVL: runLvlNext = cfgWrData; // see R10
        default: pageNext = pageReg;
      endcase
    end
  end

  // read answer; data holds between reads so a slow host can still take it
  always_comb begin
    rdValidNext = cfgRdStrobe;
    if (cfgRdStrobe) begin
      rdDataNext = readMux(cfgAddr, pageReg, src01Reg, src23Reg, invDrvReg,
          runLvlReg);
    end else begin
      rdDataNext = rdDataReg;
    end
  end

  // low half of the map is paged between the two configuration sets
  always_comb begin
    if (cfgAddr < `PPM_PAGED_LIMIT) begin
      pagedNext = {pageReg[`PPM_PAGE_BIT], cfgAddr}; // see R11
    end else begin
      pagedNext = {1'b0, cfgAddr};
    end
  end

  assign pinSel[0] = selField(src01Reg, 1'b0); // see R02
  assign pinSel[1] = selField(src01Reg, 1'b1); // see R01
  assign pinSel[2] = selField(src23Reg, 1'b0); // see R04
  assign pinSel[3] = selField(src23Reg, 1'b1); // see R03

  // pins 2 and 3 have no polarity control here; running is active high
  assign runLevel[0] = levelFor(configBActive, runLvlReg[`PPM_RUN_P0B],
      runLvlReg[`PPM_RUN_P0A]); // see R09 R10
  assign runLevel[1] = levelFor(configBActive, runLvlReg[`PPM_RUN_P1B],
      runLvlReg[`PPM_RUN_P1A]); // see R07 R08
  assign runLevel[2] = 1'b1;
  assign runLevel[3] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      ppm_src_sel #(
        .CLKOUT_ALLOWED(gi != 3) // see R03
      ) u_sel (
        .sel(pinSel[gi]),
        .invert(invDrvReg[`PPM_INV_LSB + gi]), // see R05 R12
        .runningLevel(runLevel[gi]),
        .clkOut(clkOut),
        .running(running),
        .interruptRequestN(interruptRequestN),
        .dataOut(dataOut),
        .matchedFilterData(matchedFilterData),
        .chipData(chipData),
        .chipStrobe(chipStrobe),
        .receivedData(receivedData),
        .receivedStrobe(receivedStrobe),
        .pinValue(pinComb[gi])
      );
    end
  endgenerate

  // pins are registered, so they lag their sources by one clock
  always_comb begin
    pinNext = pinComb;
    drvNext = invDrvReg[`PPM_DRV_LSB +: 4]; // see R06
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pageReg <= `PPM_RST_PAGE;
      src01Reg <= `PPM_RST_SRC01; // see R01 R02
      src23Reg <= `PPM_RST_SRC23; // see R03 R04
      invDrvReg <= `PPM_RST_INVDRV; // see R05 R06
      runLvlReg <= `PPM_RST_RUNLVL; // see R07 R08 R09 R10
    end else begin
      pageReg <= pageNext;
      src01Reg <= src01Next;
      src23Reg <= src23Next;
      invDrvReg <= invDrvNext;
      runLvlReg <= runLvlNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdDataReg <= `PPM_UNMAPPED_DATA;
      rdValidReg <= 1'b0;
    end else begin
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pagedReg <= 9'h000;
    end else begin
      pagedReg <= pagedNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinReg <= 4'h0;
      drvReg <= 4'h0;
    end else begin
      pinReg <= pinNext;
      drvReg <= drvNext;
    end
  end

  assign cfgRdData = rdDataReg;
  assign cfgRdValid = rdValidReg;
  assign pagedAddr = pagedReg;
  assign configPageSelect = pageReg[`PPM_PAGE_BIT];
  assign portPin = pinReg;
  assign pinStrongDrive = drvReg;

endmodule : ppm_port_pin_mux

//--- verification/ppm_host_model.sv
// host side model that samples the port pins
`timescale 1ns/1ps
module ppm_host_model (
  input wire logic clk,
  input wire logic [3:0] portPin,
  output logic [3:0] seenPins
);
  // mid-cycle sampling keeps clear of the pin update edge
  always_ff @(negedge clk) begin
    seenPins <= portPin;
  end
endmodule : ppm_host_model

//--- verification/ppm_port_pin_mux_checker.sv
// assertions on the port pin mux outputs
`timescale 1ns/1ps
module ppm_port_pin_mux_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgWrStrobe,
  input wire ppm_pkg::ppm_byte_t cfgAddr,
  input wire ppm_pkg::ppm_byte_t cfgWrData,
  input wire logic configBActive,
  input wire logic running,
  input wire logic interruptRequestN,
  input wire logic dataOut,
  input wire logic [3:0] portPin,
  input wire logic [3:0] pinStrongDrive
);
  import ppm_pkg::*;
  ppm_byte_t s01_reg, s23_reg, inv_reg, lvl_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s01_reg <= 8'h50;
      s23_reg <= 8'h12;
      inv_reg <= 8'h00;
      lvl_reg <= 8'hFF;
    end else if (cfgWrStrobe) begin
      if (cfgAddr == 8'h81) s01_reg <= cfgWrData;
      if (cfgAddr == 8'h82) s23_reg <= cfgWrData;
      if (cfgAddr == 8'h83) inv_reg <= cfgWrData;
      if (cfgAddr == 8'h84) lvl_reg <= cfgWrData;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  AST_P1_LOW: assert property (s01_reg[7:4] == 4'h3 |=>
    portPin[1] == $past(inv_reg[1])) else $error("pin1 low");
  AST_P0_HIGH: assert property (s01_reg[3:0] == 4'h4 |=>
    portPin[0] != $past(inv_reg[0])) else $error("pin0 high");
  AST_P3_RUN: assert property (
    s23_reg[7:4] == 4'h1 && !inv_reg[3] |=> portPin[3] == $past(running))
    else $error("pin3 run");
  AST_P2_IRQ: assert property (
    s23_reg[3:0] == 4'h2 && !inv_reg[2] |=>
    portPin[2] == $past(interruptRequestN)) else $error("pin2 irq");
  AST_P1_DATA: assert property (s01_reg[7:4] == 4'h5 |=>
    portPin[1] == ($past(dataOut) ^ $past(inv_reg[1])))
    else $error("pin1 data");
  AST_DRIVE: assert property (1'h1 |=>
    pinStrongDrive == $past(inv_reg[7:4])) else $error("drive");
  AST_P1_CFGB: assert property (
    s01_reg[7:4] == 4'h1 && configBActive && !inv_reg[1] |=>
    portPin[1] == ($past(running) == $past(lvl_reg[5])))
    else $error("pin1 cfg b");
  AST_P0_CFGA: assert property (
    s01_reg[3:0] == 4'h1 && !configBActive && !inv_reg[0] |=>
    portPin[0] == ($past(running) == $past(lvl_reg[0])))
    else $error("pin0 cfg a");
endmodule : ppm_port_pin_mux_checker
bind ppm_port_pin_mux ppm_port_pin_mux_checker u_ppm_port_pin_mux_checker (
  .clk, .rst, .cfgWrStrobe, .cfgAddr, .cfgWrData, .configBActive, .running,
  .interruptRequestN, .dataOut, .portPin, .pinStrongDrive);

//--- verification/ppm_port_pin_mux_tb.sv
// self-checking bench for the port pin mux
`timescale 1ns/1ps
module ppm_port_pin_mux_tb;
  import ppm_pkg::*;
  logic clk = 1'h0, rst = 1'h1, wrS = 1'h0, rdS = 1'h0, cfgB = 1'h0;
  ppm_byte_t addr = 8'h00, wdat = 8'h00, rdat;
  logic rdv, pgSel;
  logic [8:0] pAddr, src = 9'h000;
  logic [3:0] pins, drv, seen;
  int bad_count = 0, checked = 0, cyc = 0;
  ppm_port_pin_mux u_ppm_port_pin_mux (.clk(clk), .rst(rst),
    .cfgWrStrobe(wrS), .cfgRdStrobe(rdS), .cfgAddr(addr),
    .cfgWrData(wdat), .cfgRdData(rdat), .cfgRdValid(rdv),
    .pagedAddr(pAddr), .configPageSelect(pgSel), .configBActive(cfgB),
    .clkOut(src[0]), .running(src[1]), .interruptRequestN(src[2]),
    .dataOut(src[3]), .matchedFilterData(src[4]), .chipData(src[5]),
    .chipStrobe(src[6]), .receivedData(src[7]), .receivedStrobe(src[8]),
    .portPin(pins), .pinStrongDrive(drv));
  ppm_host_model u_ppm_host_model (.clk(clk), .portPin(pins),
    .seenPins(seen));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // one idle cycle after each access keeps strobes from re-arming same step
  task automatic wr(input ppm_byte_t a, input ppm_byte_t d);
    addr = a;
    wdat = d;
    wrS = 1'h1;
    @(negedge clk);
    wrS = 1'h0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input ppm_byte_t a, input ppm_byte_t e);
    addr = a;
    rdS = 1'h1;
    @(negedge clk);
    rdS = 1'h0;
    chk(rdv, 1'h1);
    chk(rdat, e);
    @(negedge clk);
    chk(rdv, 1'h0);
  endtask : rd
  task automatic look(input logic [3:0] e);
    @(negedge clk);
    @(negedge clk);
    chk(seen, e);
  endtask : look
  function automatic int ix(input int c);
    int t[16] = '{0, 1, 2, 0, 0, 3, 4, 0, 5, 6, 7, 8, 0, 0, 0, 0};
    return t[c];
  endfunction : ix
  function automatic logic ex(input int c, input logic [8:0] s);
    if (c == 4) return 1'h1;
    if (c == 3 || c == 7 || c > 11) return 1'h0;
    return s[ix(c)];
  endfunction : ex
  task automatic t_reset;
    ppm_byte_t rv[5] = '{8'h00, 8'h50, 8'h12, 8'h00, 8'hFF};
    src = 9'h005;
    for (int i = 0; i < 5; i++) rd(8'h80 + i[7:0], rv[i]);
    look(4'h5);
    chk(drv, 4'h0);
  endtask : t_reset
  task automatic t_codes;
    logic e;
    for (int c = 0; c < 16; c++) begin
      wr(8'h81, {2{c[3:0]}});
      wr(8'h82, {2{c[3:0]}});
      for (int v = 0; v < 2; v++) begin
        src = (9'h001 << ix(c)) ^ {9{v == 0}};
        e = ex(c, src);
        look({c == 0 ? 1'h0 : e, e, e, e});
      end
    end
  endtask : t_codes
  task automatic t_inv;
    wr(8'h81, 8'h44);
    wr(8'h82, 8'h44);
    wr(8'h83, 8'hA5);
    look(4'hA);
    chk(drv, 4'hA);
    wr(8'h81, 8'h33);
    wr(8'h82, 8'h33);
    look(4'h5);
    rd(8'h83, 8'hA5);
    wr(8'h83, 8'h00);
  endtask : t_inv
  task automatic t_run;
    wr(8'h81, 8'h11);
    wr(8'h82, 8'h11);
    for (int i = 0; i < 8; i++) begin
      cfgB = i[2];
      wr(8'h84, {2{2'h3, i[2] == i[1], i[2] != i[1]}});
      src = {7'h00, i[0], 1'h0};
      look({{2{i[0]}}, {2{i[0] == i[1]}}});
    end
  endtask : t_run
  task automatic t_page;
    wr(8'h80, 8'hFF);
    rd(8'h80, 8'h01);
    chk(pgSel, 1'h1);
    addr = 8'h12;
    @(negedge clk);
    @(negedge clk);
    chk(pAddr, 9'h112);
    wr(8'h90, 8'h5A);
    rd(8'h90, 8'h00);
    chk(pAddr, 9'h090);
    wr(8'h80, 8'h00);
    chk(pgSel, 1'h0);
    addr = 8'h12;
    @(negedge clk);
    @(negedge clk);
    chk(pAddr, 9'h012);
  endtask : t_page
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_codes();
    t_inv();
    t_run();
    t_page();
    close_out();
  end
endmodule : ppm_port_pin_mux_tb
